// *** quad_decoder.sv ***
// shared constants and the encoder channel synchroniser / quadrature decoder
`timescale 1ns/100ps
`default_nettype none

package encpos_pkg;
  // clock and millisecond timebase
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_PERIOD_NS  = 1000000;
  localparam int MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;
  // widths
  localparam int POS_W         = 36;   // holds ten signed decimal digits
  localparam int SET_W         = 16;
  // factory defaults of the settings
  localparam logic [SET_W-1:0] FE_LIMIT_RST = 16'h000A;  // 10 full steps
  localparam logic [SET_W-1:0] ATTEMPT_RST  = 16'h0064;  // 100 attempts
  localparam logic [SET_W-1:0] DELAY_MS_RST = 16'h0064;  // 100 ms
  localparam logic [SET_W-1:0] BAND_RST     = 16'h0002;
  localparam logic [1:0]       MODE_RST     = 2'h0;
  localparam logic [3:0]       SCALE_RST    = 4'h4;
  localparam logic             INVERT_RST   = 1'b0;
  // scale factor setting that multiplies instead of divides
  localparam logic [3:0]       SCALE_MUL    = 4'h5;
  localparam logic [5:0]       MUL_STEP     = 6'h05;
  // verification modes
  localparam logic [1:0]       MODE_OFF     = 2'h0;
  localparam logic [1:0]       MODE_ABORT   = 2'h1;
  localparam logic [1:0]       MODE_RETURN  = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_FE_WAIT, ST_SETTLE} loop_state_t;
endpackage : encpos_pkg

module quad_decoder (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic enc_a_i,
  input  wire logic enc_b_i,
  output logic      count_up_o,
  output logic      count_dn_o
);
  logic a_meta, b_meta, a_sync, b_sync, a_prev, b_prev;
  logic next_up, next_dn;
  logic a_chg, b_chg;

  // one edge on exactly one channel is a count; direction from phase order
  always_comb begin
    a_chg   = a_sync ^ a_prev;
    b_chg   = b_sync ^ b_prev;
    next_up = (a_chg ^ b_chg) & (a_sync ^ b_prev);
    next_dn = (a_chg ^ b_chg) & ~(a_sync ^ b_prev);
  end

  // two-stage synchroniser, then edge history and count pulses
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      a_meta     <= 1'b0;
      b_meta     <= 1'b0;
      a_sync     <= 1'b0;
      b_sync     <= 1'b0;
      a_prev     <= 1'b0;
      b_prev     <= 1'b0;
      count_up_o <= 1'b0;
      count_dn_o <= 1'b0;
    end else begin
      a_meta     <= enc_a_i;
      b_meta     <= enc_b_i;
      a_sync     <= a_meta;
      b_sync     <= b_meta;
      a_prev     <= a_sync;
      b_prev     <= b_sync;
      count_up_o <= next_up;
      count_dn_o <= next_dn;
    end
  end
endmodule : quad_decoder

`default_nettype wire

// *** encoder_position_verify.sv ***
// closed-loop position verification for the x axis
// Behaviour
// - Scale setting 5 multiplies each counted quadrature edge by five.
// - Other scale settings divide counted edges by the setting value, setting 0 by one.
// - Following error limit defaults to 10 full steps.
// - Correction attempt count is programmable, default 100.
// - Delay between attempts in milliseconds, default 100 ms.
// - Set home clears electrical and encoder positions; both readable signed.
// - Clockwise move of N pulses gives electrical +N and encoder N.
// - Invert setting reverses encoder counting sense.
// - Verification mode accepts 0 to 3.
// - Following error during motion stops motion at once, no ramp.
// - At standstill, deviation beyond band moves motor to band centre.
// - After delay, with attempts left, restart cycle and decrement count.
// - On termination after following error, encoder copied to electrical.
`timescale 1ns/100ps
`default_nettype none

module encoder_position_verify #(
  parameter int CYCLES_PER_MS = encpos_pkg::MS_CYCLES
) (
  input  wire logic                           mclk_i,
  input  wire logic                           rst_i,
  input  wire logic                           enc_a_i,
  input  wire logic                           enc_b_i,
  input  wire logic                           cmd_step_i,
  input  wire logic                           cmd_cw_i,
  input  wire logic                           motion_active_i,
  input  wire logic                           cycle_start_i,
  input  wire logic                           set_home_cmd_i,
  input  wire logic                           settings_load_i,
  input  wire logic [1:0]                     verify_mode_select_i,
  input  wire logic [encpos_pkg::SET_W-1:0]   following_error_limit_i,
  input  wire logic [encpos_pkg::SET_W-1:0]   in_position_band_i,
  input  wire logic                           encoder_dir_invert_i,
  input  wire logic [3:0]                     quad_scale_factor_i,
  input  wire logic [encpos_pkg::SET_W-1:0]   correction_attempt_limit_i,
  input  wire logic [encpos_pkg::SET_W-1:0]   correction_delay_ms_i,
  output logic signed [encpos_pkg::POS_W-1:0] electrical_pos_o,
  output logic signed [encpos_pkg::POS_W-1:0] encoder_pos_o,
  output logic signed [encpos_pkg::POS_W-1:0] pulse_error_o,
  output logic [encpos_pkg::SET_W-1:0]        attempts_left_o,
  output logic                                stop_now_o,
  output logic                                restart_cycle_o,
  output logic                                restart_to_origin_o,
  output logic                                terminate_o,
  output logic                                loop_fault_o,
  output logic                                correct_req_o,
  output logic signed [encpos_pkg::POS_W-1:0] correct_dist_o,
  output logic                                in_position_o
);
  localparam int PW = encpos_pkg::POS_W;
  localparam int SW = encpos_pkg::SET_W;
  localparam int DW = $clog2(CYCLES_PER_MS);
  localparam logic [DW-1:0] TICK_LAST = DW'(CYCLES_PER_MS - 1);

  // magnitude of a signed position difference
  function automatic logic [PW-1:0] mag(input logic signed [PW-1:0] v);
    mag = v[PW-1] ? PW'(-v) : PW'(v);
  endfunction : mag

  logic              count_up, count_dn;
  // settings
  logic [1:0]        mode, next_mode;
  logic [SW-1:0]     fe_lim, next_fe_lim, band, next_band;
  logic [SW-1:0]     att_lim, next_att_lim, dly_ms, next_dly_ms;
  logic              inv, next_inv;
  logic [3:0]        scale, next_scale;
  // positions
  logic signed [PW-1:0] next_elec, next_enc, next_err;
  logic signed [5:0] resid, next_resid;
  logic signed [5:0] divisor;
  logic              up, dn;
  // loop control
  encpos_pkg::loop_state_t state, next_state;
  logic [DW-1:0]     tick_cnt, next_tick_cnt;
  logic [SW-1:0]     ms_left, next_ms_left, next_att;
  logic              next_stop, next_restart, next_origin, next_term, next_fault;
  logic              next_corr, next_inpos;
  logic signed [PW-1:0] next_cdist;
  logic              tick, delay_done;

  quad_decoder u_quad (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .enc_a_i    (enc_a_i),
    .enc_b_i    (enc_b_i),
    .count_up_o (count_up),
    .count_dn_o (count_dn)
  );

  // settings hold factory defaults until software loads new ones
  always_comb begin
    next_mode    = mode;
    next_fe_lim  = fe_lim;
    next_band    = band;
    next_att_lim = att_lim;
    next_dly_ms  = dly_ms;
    next_inv     = inv;
    next_scale   = scale;
    if (settings_load_i) begin
      next_mode    = verify_mode_select_i;
      next_fe_lim  = following_error_limit_i;
      next_band    = in_position_band_i;
      next_att_lim = correction_attempt_limit_i;
      next_dly_ms  = correction_delay_ms_i;
      next_inv     = encoder_dir_invert_i;
      next_scale   = quad_scale_factor_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode    <= encpos_pkg::MODE_RST;
      fe_lim  <= encpos_pkg::FE_LIMIT_RST;
      band    <= encpos_pkg::BAND_RST;
      att_lim <= encpos_pkg::ATTEMPT_RST;
      dly_ms  <= encpos_pkg::DELAY_MS_RST;
      inv     <= encpos_pkg::INVERT_RST;
      scale   <= encpos_pkg::SCALE_RST;
    end else begin
      mode    <= next_mode;
      fe_lim  <= next_fe_lim;
      band    <= next_band;
      att_lim <= next_att_lim;
      dly_ms  <= next_dly_ms;
      inv     <= next_inv;
      scale   <= next_scale;
    end
  end

  // electrical position from step pulses, encoder position from scaled edges
  always_comb begin
    up         = inv ? count_dn : count_up;
    dn         = inv ? count_up : count_dn;
    divisor    = (scale == 4'h0) ? 6'sh01 : $signed({2'h0, scale});
    next_elec  = electrical_pos_o;
    next_enc   = encoder_pos_o;
    next_resid = resid;
    if (cmd_step_i) begin
      next_elec = cmd_cw_i ? electrical_pos_o + PW'(1) : electrical_pos_o - PW'(1);
    end
    if (scale == encpos_pkg::SCALE_MUL) begin
      next_resid = 6'sh00;
      if (up) begin
        next_enc = encoder_pos_o + PW'(encpos_pkg::MUL_STEP);
      end else if (dn) begin
        next_enc = encoder_pos_o - PW'(encpos_pkg::MUL_STEP);
      end
    end else if (up) begin
      next_resid = resid + 6'sh01;
      if (next_resid >= divisor) begin
        next_resid = 6'sh00;
        next_enc   = encoder_pos_o + PW'(1);
      end
    end else if (dn) begin
      next_resid = resid - 6'sh01;
      if (next_resid <= -divisor) begin
        next_resid = 6'sh00;
        next_enc   = encoder_pos_o - PW'(1);
      end
    end
    if (state == encpos_pkg::ST_FE_WAIT && delay_done &&
        (mode == encpos_pkg::MODE_ABORT || attempts_left_o == '0)) begin
      next_elec = encoder_pos_o;
    end
    if (set_home_cmd_i) begin
      next_elec  = '0;
      next_enc   = '0;
      next_resid = 6'sh00;
    end
    next_err = next_elec - next_enc;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      electrical_pos_o <= '0;
      encoder_pos_o    <= '0;
      pulse_error_o    <= '0;
      resid            <= 6'sh00;
    end else begin
      electrical_pos_o <= next_elec;
      encoder_pos_o    <= next_enc;
      pulse_error_o    <= next_err;
      resid            <= next_resid;
    end
  end

  // millisecond delay timer and closed-loop sequencing
  always_comb begin
    tick          = (tick_cnt == TICK_LAST);
    delay_done    = (ms_left == '0);
    next_state    = state;
    next_tick_cnt = tick ? '0 : tick_cnt + DW'(1);
    next_ms_left  = (tick && !delay_done) ? ms_left - SW'(1) : ms_left;
    next_att      = attempts_left_o;
    next_stop     = stop_now_o;
    next_restart  = 1'b0;
    next_origin   = restart_to_origin_o;
    next_term     = 1'b0;
    next_fault    = loop_fault_o;
    next_corr     = 1'b0;
    next_cdist    = correct_dist_o;
    next_inpos    = (mag(pulse_error_o) <= PW'(band));
    if (cycle_start_i) begin
      next_att    = att_lim;        // fresh non-correction cycle reloads attempts
      next_fault  = 1'b0;
      next_origin = 1'b0;
      next_stop   = 1'b0;
    end
    unique case (state)
      encpos_pkg::ST_IDLE: begin
        if (motion_active_i) begin
          next_state = encpos_pkg::ST_MOVE;
        end else if (mode != encpos_pkg::MODE_OFF) begin
          next_state = encpos_pkg::ST_SETTLE;
        end
        next_tick_cnt = '0;
        next_ms_left  = dly_ms;
      end
      encpos_pkg::ST_MOVE: begin
        next_tick_cnt = '0;
        next_ms_left  = dly_ms;
        if (mode != encpos_pkg::MODE_OFF && mag(pulse_error_o) > PW'(fe_lim)) begin
          next_stop  = 1'b1;
          next_state = encpos_pkg::ST_FE_WAIT;
        end else if (!motion_active_i) begin
          next_state = encpos_pkg::ST_IDLE;   // settle delay starts at motion end
        end
      end
      encpos_pkg::ST_FE_WAIT: begin
        if (delay_done) begin
          next_stop  = 1'b0;
          next_state = encpos_pkg::ST_IDLE;
          if (mode == encpos_pkg::MODE_ABORT || attempts_left_o == '0) begin
            next_term  = 1'b1;
            next_fault = 1'b1;
          end else begin
            next_restart = 1'b1;
            next_att     = attempts_left_o - SW'(1);
            next_origin  = (mode == encpos_pkg::MODE_RETURN) & ~restart_to_origin_o;
          end
        end
      end
      encpos_pkg::ST_SETTLE: begin
        if (motion_active_i) begin
          next_state = encpos_pkg::ST_MOVE;
        end else if (mode == encpos_pkg::MODE_OFF) begin
          next_state = encpos_pkg::ST_IDLE;
        end else if (delay_done && mag(pulse_error_o) > PW'(band)) begin
          next_corr     = 1'b1;
          next_cdist    = pulse_error_o;   // steps that bring encoder to ideal
          next_ms_left  = dly_ms;
          next_tick_cnt = '0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state               <= encpos_pkg::ST_IDLE;
      tick_cnt            <= '0;
      ms_left             <= encpos_pkg::DELAY_MS_RST;
      attempts_left_o     <= encpos_pkg::ATTEMPT_RST;
      stop_now_o          <= 1'b0;
      restart_cycle_o     <= 1'b0;
      restart_to_origin_o <= 1'b0;
      terminate_o         <= 1'b0;
      loop_fault_o        <= 1'b0;
      correct_req_o       <= 1'b0;
      correct_dist_o      <= '0;
      in_position_o       <= 1'b1;
    end else begin
      state               <= next_state;
      tick_cnt            <= next_tick_cnt;
      ms_left             <= next_ms_left;
      attempts_left_o     <= next_att;
      stop_now_o          <= next_stop;
      restart_cycle_o     <= next_restart;
      restart_to_origin_o <= next_origin;
      terminate_o         <= next_term;
      loop_fault_o        <= next_fault;
      correct_req_o       <= next_corr;
      correct_dist_o      <= next_cdist;
      in_position_o       <= next_inpos;
    end
  end
endmodule : encoder_position_verify

`default_nettype wire

// *** quad_encoder_model.sv ***
// quadrature encoder model driving the a and b channels
`timescale 1ns/100ps
`default_nettype none
module quad_encoder_model (
  input  wire logic mclk_i,
  output logic      enc_a_o,
  output logic      enc_b_o
);
  logic [1:0] phase = 2'h0;
  // gray order: a rises ahead of b when turning forward
  assign enc_a_o = phase[1] ^ phase[0];
  assign enc_b_o = phase[1];
  // one channel change per edge, edges three clocks apart
  task move(input int n, input bit fwd);
    repeat (n) begin
      @(posedge mclk_i);
      #2;
      phase = fwd ? phase + 2'h1 : phase - 2'h1;
      repeat (2) @(posedge mclk_i);
    end
  endtask : move
endmodule : quad_encoder_model
`default_nettype wire

// *** encoder_position_verify_monitor.sv ***
// assertion checker for the position verification block
`timescale 1ns/100ps
`default_nettype none
module encoder_position_verify_monitor (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        enc_a_i,
  input wire logic        enc_b_i,
  input wire logic        cmd_step_i,
  input wire logic        cmd_cw_i,
  input wire logic        cycle_start_i,
  input wire logic        set_home_cmd_i,
  input wire logic signed [encpos_pkg::POS_W-1:0] electrical_pos_o,
  input wire logic signed [encpos_pkg::POS_W-1:0] encoder_pos_o,
  input wire logic signed [encpos_pkg::POS_W-1:0] pulse_error_o,
  input wire logic        [encpos_pkg::SET_W-1:0] attempts_left_o,
  input wire logic        stop_now_o,
  input wire logic        restart_cycle_o,
  input wire logic        terminate_o,
  input wire logic        loop_fault_o,
  input wire logic        correct_req_o,
  input wire logic signed [encpos_pkg::POS_W-1:0] correct_dist_o,
  input wire logic        in_position_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // defaults, home, step tracking and error difference
  a_reset_default: assert property ($fell(rst_i) |-> attempts_left_o == 16'h0064)
    else $error("attempt count not at default after reset");
  a_home_clear: assert property (set_home_cmd_i |=> electrical_pos_o == 0 && encoder_pos_o == 0)
    else $error("home did not clear positions");
  a_step_track: assert property (cmd_step_i && !set_home_cmd_i |=> terminate_o ||
    electrical_pos_o - $past(electrical_pos_o) == ($past(cmd_cw_i) ? 36'sh1 : -36'sh1))
    else $error("electrical position did not follow step");
  a_error_diff: assert property (pulse_error_o == electrical_pos_o - encoder_pos_o)
    else $error("pulse error not electrical minus encoder");
  // encoder count moves only after synchronised pin activity
  a_enc_quiet: assert property (!$past(set_home_cmd_i) && $past(enc_a_i, 2) == $past(enc_a_i, 5)
    && $past(enc_b_i, 2) == $past(enc_b_i, 5) |-> $stable(encoder_pos_o))
    else $error("encoder count moved without pin edge");
  // fault handling and standstill correction
  a_stop_hold: assert property ($rose(stop_now_o) |-> stop_now_o [*2])
    else $error("stop released too early");
  a_term_copy: assert property (terminate_o |-> loop_fault_o && electrical_pos_o == encoder_pos_o)
    else $error("termination without fault or copy");
  a_pulse_once: assert property (restart_cycle_o || terminate_o |=> !restart_cycle_o && !terminate_o)
    else $error("restart or terminate longer than one cycle");
  a_restart_dec: assert property (restart_cycle_o |-> attempts_left_o == $past(attempts_left_o) - 16'h0001)
    else $error("attempt count not decremented");
  a_correct_dist: assert property (correct_req_o |-> correct_dist_o == pulse_error_o)
    else $error("correction distance wrong");
  a_cycle_clear: assert property (cycle_start_i |=> terminate_o || !loop_fault_o && !stop_now_o)
    else $error("cycle start did not clear fault");
endmodule : encoder_position_verify_monitor
bind encoder_position_verify encoder_position_verify_monitor u_mon (
  .mclk_i, .rst_i, .enc_a_i, .enc_b_i, .cmd_step_i, .cmd_cw_i, .cycle_start_i, .set_home_cmd_i,
  .electrical_pos_o, .encoder_pos_o, .pulse_error_o, .attempts_left_o, .stop_now_o,
  .restart_cycle_o, .terminate_o, .loop_fault_o, .correct_req_o, .correct_dist_o, .in_position_o
);
`default_nettype wire

// *** encoder_position_verify_tb_top.sv ***
// self-checking testbench for the position verification block
`timescale 1ns/100ps
`default_nettype none
module encoder_position_verify_tb_top;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  wire logic enc_a_i, enc_b_i;
  logic cmd_step_i, cmd_cw_i, motion_active_i, cycle_start_i, set_home_cmd_i, settings_load_i;
  logic [1:0] verify_mode_select_i;
  logic [15:0] following_error_limit_i, in_position_band_i, correction_attempt_limit_i;
  logic [15:0] correction_delay_ms_i;
  logic encoder_dir_invert_i;
  logic [3:0] quad_scale_factor_i;
  logic signed [35:0] electrical_pos_o, encoder_pos_o, pulse_error_o, correct_dist_o;
  logic [15:0] attempts_left_o;
  logic stop_now_o, restart_cycle_o, restart_to_origin_o, terminate_o, loop_fault_o;
  logic correct_req_o, in_position_o;
  int error_cnt = 0;
  int checked = 0;
  int scales[4] = '{4, 2, 8, 5};
  encoder_position_verify #(.CYCLES_PER_MS(4)) u_dut (
    .mclk_i, .rst_i, .enc_a_i, .enc_b_i, .cmd_step_i, .cmd_cw_i, .motion_active_i,
    .cycle_start_i, .set_home_cmd_i, .settings_load_i, .verify_mode_select_i,
    .following_error_limit_i, .in_position_band_i, .encoder_dir_invert_i, .quad_scale_factor_i,
    .correction_attempt_limit_i, .correction_delay_ms_i, .electrical_pos_o, .encoder_pos_o,
    .pulse_error_o, .attempts_left_o, .stop_now_o, .restart_cycle_o, .restart_to_origin_o,
    .terminate_o, .loop_fault_o, .correct_req_o, .correct_dist_o, .in_position_o
  );
  quad_encoder_model u_enc (.mclk_i, .enc_a_o(enc_a_i), .enc_b_o(enc_b_i));
  initial forever #20 mclk_i = ~mclk_i;
  task tick(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask : tick
  task chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // bounded wait: 0 terminate, 1 restart, 2 correction
  task waitp(input int w);
    for (int i = 0; i < 200; i++) begin
      tick(1);
      if ((w == 0 ? terminate_o : w == 1 ? restart_cycle_o : correct_req_o) === 1'b1) return;
    end
    error_cnt++;
    report_and_stop();
  endtask : waitp
  task load(input logic [1:0] m, input logic [15:0] lim, input logic [3:0] sc, input logic inv);
    verify_mode_select_i = m;
    following_error_limit_i = lim;
    quad_scale_factor_i = sc;
    encoder_dir_invert_i = inv;
    settings_load_i = 1'b1;
    tick(1);
    settings_load_i = 1'b0;
  endtask : load
  task home;
    set_home_cmd_i = 1'b1;
    tick(1);
    set_home_cmd_i = 1'b0;
    tick(1);
  endtask : home
  task start;
    cycle_start_i = 1'b1;
    tick(1);
    cycle_start_i = 1'b0;
  endtask : start
  task steps(input int n, input logic cw);
    cmd_cw_i = cw;
    cmd_step_i = 1'b1;
    tick(n);
    cmd_step_i = 1'b0;
    tick(1);
  endtask : steps
  // one motion that ends in a following error, then wait for the outcome
  task fe_run(input int w);
    motion_active_i = 1'b1;
    steps(6, 1'b1);
    tick(1);
    chk("stop", stop_now_o, 1);
    motion_active_i = 1'b0;
    waitp(w);
  endtask : fe_run
  task t_scale;
    for (int i = 0; i < 4; i++) begin
      load(2'h0, 16'h000A, scales[i][3:0], 1'b0);
      home();
      u_enc.move(8, 1'b1);
      tick(6);
      chk("encoder", encoder_pos_o, scales[i] == 5 ? 40 : 8 / scales[i]);
    end
    load(2'h0, 16'h000A, 4'h5, 1'b1);
    home();
    u_enc.move(4, 1'b1);
    tick(6);
    chk("inverted", encoder_pos_o, -20);
    load(2'h0, 16'h000A, 4'h4, 1'b0);
    home();
    u_enc.move(4, 1'b0);
    tick(6);
    chk("reverse", encoder_pos_o, -1);
  endtask : t_scale
  task t_steps;
    steps(7, 1'b1);
    steps(2, 1'b0);
    chk("electrical", electrical_pos_o, 5);
    chk("error", pulse_error_o, 6);
    home();
    chk("home elec", electrical_pos_o, 0);
    chk("home enc", encoder_pos_o, 0);
  endtask : t_steps
  task t_fault;
    load(2'h1, 16'h0004, 4'h4, 1'b0);
    start();
    u_enc.move(4, 1'b1);
    tick(6);
    fe_run(0);
    chk("fault", loop_fault_o, 1);
    chk("copied", electrical_pos_o, 1);
    start();
    load(2'h2, 16'h0004, 4'h4, 1'b0);
    fe_run(1);
    chk("attempts", attempts_left_o, 2);
    load(2'h3, 16'h0004, 4'h4, 1'b0);
    fe_run(1);
    chk("attempts", attempts_left_o, 1);
    chk("origin", restart_to_origin_o, 1);
    fe_run(1);
    fe_run(0);
    chk("exhausted", attempts_left_o, 0);
  endtask : t_fault
  task t_corr;
    start();
    load(2'h2, 16'h000A, 4'h4, 1'b0);
    home();
    motion_active_i = 1'b1;
    steps(3, 1'b1);
    motion_active_i = 1'b0;
    waitp(2);
    chk("distance", correct_dist_o, 3);
    chk("in position", in_position_o, 0);
    // band widened to cover mechanical lash, still below the following error limit
    in_position_band_i = 16'h0005;
    load(2'h2, 16'h000A, 4'h4, 1'b0);
    tick(1);
    chk("wide band", in_position_o, 1);
    // an error inside the wider band must not ask for correction
    repeat (20) begin
      tick(1);
      chk("no correction", correct_req_o, 0);
    end
  endtask : t_corr
  initial begin
    {cmd_step_i, cmd_cw_i, motion_active_i, cycle_start_i} = 4'h0;
    {set_home_cmd_i, settings_load_i, encoder_dir_invert_i} = 3'h0;
    verify_mode_select_i = 2'h0;
    following_error_limit_i = 16'h000A;
    quad_scale_factor_i = 4'h4;
    in_position_band_i = 16'h0002;
    correction_attempt_limit_i = 16'h0003;
    correction_delay_ms_i = 16'h0002;
    tick(4);
    rst_i = 1'b0; // no command reaches the block before reset is released
    chk("reset attempts", attempts_left_o, 100);
    chk("reset in position", in_position_o, 1);
    t_scale();
    t_steps();
    t_fault();
    t_corr();
    report_and_stop();
  end
endmodule : encoder_position_verify_tb_top
`default_nettype wire
